// >>> rtl/rtec_pkg.sv
// Constants, register map and types of the reset and trace exception controller
package rtec_pkg;

  // Register byte offsets
  localparam logic [7:0]  ADDR_CTRL   = 8'h00;
  localparam logic [7:0]  ADDR_EXR    = 8'h04;
  localparam logic [7:0]  ADDR_CCR    = 8'h08;
  localparam logic [7:0]  ADDR_MSTP   = 8'h0C;
  localparam logic [7:0]  ADDR_STAT   = 8'h10;
  localparam logic [7:0]  ADDR_MASK   = 8'h14;
  localparam logic [7:0]  ADDR_STATE  = 8'h18;

  // Interrupt control modes
  localparam logic [1:0]  ICM_0       = 2'h0;
  localparam logic [1:0]  ICM_2       = 2'h2;

  // Field positions
  localparam int          ICM_LSB     = 0;
  localparam int          EXR_T_BIT   = 7;
  localparam int          EXR_PRI_LSB = 0;
  localparam int          CCR_I_BIT   = 7;
  localparam int          CCR_UI_BIT  = 6;
  localparam int          ST_TRACE    = 0;
  localparam int          ST_BLOCKED  = 1;
  localparam int          ST_FIRST    = 2;
  localparam int          NUM_EVT     = 3;

  // Reset values, top priority level and module count
  localparam logic [1:0]  ICM_RESET   = 2'h0;
  localparam logic [15:0] MSTP_RESET  = 16'h3FFF;
  localparam logic [7:0]  EXR_RESET   = 8'h07;
  localparam logic [7:0]  CCR_RESET   = 8'h80;
  localparam logic [2:0]  PRI_TOP     = 3'h7;
  localparam int          NUM_MOD     = 16;

  // Reset phase of the core
  typedef enum logic [0:0] {PH_BOOT, PH_RUN} rtec_phase_e;

endpackage

// >>> rtl/rtec_mstp_gate.sv
// Module stop access gate for the on-chip supporting module registers
`timescale 1ns/1ps
module rtec_mstp_gate
  import rtec_pkg::*;
(
  // Module stop control
  input  wire logic [NUM_MOD-1:0] mstp,
  // Peripheral register access
  input  wire logic               per_req,
  input  wire logic [3:0]         per_idx,
  output logic                    per_grant,
  output logic                    per_blocked
);

  function automatic logic [NUM_MOD-1:0] onehot(input logic [3:0] idx);
    onehot = '0;
    onehot[idx] = 1'b1;
  endfunction

  wire logic stopped;

  assign stopped     = |(onehot(per_idx) & mstp);
  assign per_grant   = per_req & ~stopped;   // RQ4
  assign per_blocked = per_req & stopped;    // RQ4

endmodule

// >>> rtl/rtec_core.sv
// Reset and trace exception controller with AHB-Lite register slave
//
// Summary of operation
// (RQ1) After reset mask all interrupts including NMI
// (RQ2) First instruction runs before any interrupt
// (RQ3) Module stop register resets to 3FFF
// (RQ4) Stopped modules refuse register reads and writes
// (RQ5) Trace only in interrupt control mode 2
// (RQ6) Trace bit set: exception after each instruction
// (RQ7) Only clearing trace bit ends trace; mask ignored
// (RQ8) Trace handling sets I, clears T only
// (RQ9) Interrupts still accepted inside trace handler
// (RQ10) Stacked trace bit stays one for return
// (RQ11) No trace exception after exception return
//
// The address map and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/1ps
module rtec_core
  import rtec_pkg::*;
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Instruction sequencer
  input  wire logic        instr_done,
  input  wire logic        instr_is_rte,
  input  wire logic        rte_exr_t,
  output logic             trace_exc_req,
  output logic             stacked_exr_t,
  // Interrupt requests
  input  wire logic        nmi_req,
  input  wire logic        irq_req,
  input  wire logic [2:0]  irq_level,
  output logic             int_accept,
  // Peripheral register access
  input  wire logic        per_req,
  input  wire logic [3:0]  per_idx,
  output logic             per_grant,
  output logic             per_blocked,
  // Interrupt output
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // State

  rtec_phase_e          phase;
  rtec_phase_e          next_phase;
  logic [1:0]           icm;
  logic [7:0]           extended_control_reg;
  logic [7:0]           condition_code_reg;
  logic [NUM_MOD-1:0]   mstp;
  logic [NUM_EVT-1:0]   stat;
  logic [NUM_EVT-1:0]   mask;
  logic                 dp_wr;
  logic [7:0]           dp_addr;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus decode

  wire logic            ap_valid;
  wire logic            wr_ctrl;
  wire logic            wr_exr;
  wire logic            wr_ccr;
  wire logic            wr_mstp;
  wire logic            wr_stat;
  wire logic            wr_mask;

  assign ap_valid  = hsel & htrans[1] & hready;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign wr_ctrl   = dp_wr & (dp_addr == ADDR_CTRL);
  assign wr_exr    = dp_wr & (dp_addr == ADDR_EXR);
  assign wr_ccr    = dp_wr & (dp_addr == ADDR_CCR);
  assign wr_mstp   = dp_wr & (dp_addr == ADDR_MSTP);
  assign wr_stat   = dp_wr & (dp_addr == ADDR_STAT);
  assign wr_mask   = dp_wr & (dp_addr == ADDR_MASK);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr   <= 1'b0;
      dp_addr <= 8'h00;
    end else begin
      dp_wr   <= ap_valid & hwrite & (hsize == 3'h2);
      dp_addr <= ap_valid ? haddr[7:0] : dp_addr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Trace and interrupt decisions

  wire logic            trace_on;
  wire logic            trace_hit;
  wire logic            mode2_ok;
  wire logic            mode0_ok;

  assign trace_on  = (icm == ICM_2) & extended_control_reg[EXR_T_BIT];                // RQ5 RQ7
  assign trace_hit = instr_done & trace_on & ~instr_is_rte;          // RQ6 RQ11
  assign mode2_ok  = (irq_level > extended_control_reg[EXR_PRI_LSB +: 3]) | (irq_level == PRI_TOP);
  assign mode0_ok  = ~condition_code_reg[CCR_I_BIT];
  assign int_accept = (phase == PH_RUN)
                      & (nmi_req | (irq_req & ((icm == ICM_2) ? mode2_ok : mode0_ok)));
  // RQ1 RQ2 RQ9
  assign next_phase = (phase == PH_BOOT && instr_done) ? PH_RUN : phase;  // RQ2

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase <= PH_BOOT;                                                  // RQ1
    end else begin
      phase <= next_phase;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trace_exc_req <= 1'b0;
      stacked_exr_t <= 1'b0;
    end else begin
      trace_exc_req <= trace_hit;                                        // RQ6
      if (trace_hit) begin
        stacked_exr_t <= extended_control_reg[EXR_T_BIT];                                 // RQ10
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control registers

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      icm  <= ICM_RESET;
      mstp <= MSTP_RESET;                                                // RQ3
      mask <= '0;
    end else begin
      if (wr_ctrl && (hwdata[ICM_LSB +: 2] == ICM_0 || hwdata[ICM_LSB +: 2] == ICM_2)) begin
        icm <= hwdata[ICM_LSB +: 2];
      end
      if (wr_mstp) begin
        mstp <= hwdata[NUM_MOD-1:0];
      end
      if (wr_mask) begin
        mask <= hwdata[NUM_EVT-1:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      extended_control_reg <= EXR_RESET;
      condition_code_reg <= CCR_RESET;
    end else if (trace_hit) begin
      extended_control_reg[EXR_T_BIT] <= 1'b0;                                            // RQ8
      condition_code_reg[CCR_I_BIT] <= 1'b1;                                            // RQ8
    end else if (instr_done && instr_is_rte) begin
      extended_control_reg[EXR_T_BIT] <= rte_exr_t;                                       // RQ10
    end else begin
      if (wr_exr) begin
        extended_control_reg <= {hwdata[EXR_T_BIT], 4'h0, hwdata[EXR_PRI_LSB +: 3]};
      end
      if (wr_ccr) begin
        condition_code_reg <= {hwdata[CCR_I_BIT], hwdata[CCR_UI_BIT], 6'h00};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Events, status and interrupt

  wire logic [NUM_EVT-1:0] evt;

  assign evt[ST_TRACE]   = trace_hit;
  assign evt[ST_BLOCKED] = per_blocked;
  assign evt[ST_FIRST]   = (phase == PH_BOOT) & instr_done;
  assign irq             = |(stat & mask);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat <= '0;
    end else begin
      stat <= (stat & ~(wr_stat ? hwdata[NUM_EVT-1:0] : '0)) | evt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read mux

  always_comb begin
    hrdata = 32'h0000_0000;
    unique case (dp_addr)
      ADDR_CTRL:  hrdata[1:0]         = icm;
      ADDR_EXR:   hrdata[7:0]         = extended_control_reg;
      ADDR_CCR:   hrdata[7:0]         = condition_code_reg;
      ADDR_MSTP:  hrdata[NUM_MOD-1:0] = mstp;
      ADDR_STAT:  hrdata[NUM_EVT-1:0] = stat;
      ADDR_MASK:  hrdata[NUM_EVT-1:0] = mask;
      ADDR_STATE: hrdata[1:0]         = {trace_on, phase == PH_BOOT};
      default:    hrdata              = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Module stop gate

  rtec_mstp_gate u_gate (
    .mstp        (mstp),
    .per_req     (per_req),
    .per_idx     (per_idx),
    .per_grant   (per_grant),
    .per_blocked (per_blocked)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_trace_done;
    instr_done && !instr_is_rte && icm == ICM_2 && extended_control_reg[EXR_T_BIT];
  endsequence

  sequence s_trace_effect;
    trace_exc_req && !extended_control_reg[EXR_T_BIT] && condition_code_reg[CCR_I_BIT];
  endsequence

  a_boot_no_int: assert property (phase == PH_BOOT |-> !int_accept) // RQ1
    else $error("Interrupt accepted before first instruction");
  a_first_instr: assert property (phase == PH_BOOT && instr_done |=> phase == PH_RUN) // RQ2
    else $error("Boot phase did not end after first instruction");
  a_mstp_reset: assert property ($rose(hresetn) |-> mstp == MSTP_RESET) // RQ3
    else $error("Module stop register wrong after reset");
  a_stop_blocks: assert property (per_req && mstp[per_idx] |-> !per_grant && per_blocked) // RQ4
    else $error("Stopped module access granted");
  a_mode0_notrace: assert property (icm == ICM_0 |=> !trace_exc_req) // RQ5
    else $error("Trace raised in mode 0");
  a_trace_raise: assert property (s_trace_done |=> trace_exc_req) // RQ6
    else $error("Trace exception missing");
  a_trace_holds: assert property (extended_control_reg[EXR_T_BIT] && !trace_hit && !wr_exr
                                  && !(instr_done && instr_is_rte) |=> extended_control_reg[EXR_T_BIT]) // RQ7
    else $error("Trace bit dropped without clear");
  a_trace_effect: assert property (s_trace_done |=> s_trace_effect and // RQ8
                                   ($stable(condition_code_reg[CCR_UI_BIT])
                                    && $stable(extended_control_reg[EXR_PRI_LSB +: 3])))
    else $error("Trace handling changed wrong bits");
  a_nmi_in_trace: assert property (phase == PH_RUN && nmi_req |-> int_accept) // RQ9
    else $error("NMI refused in run phase");
  a_stacked_one: assert property (s_trace_done |=> stacked_exr_t) // RQ10
    else $error("Stacked trace bit not one");
  a_rte_notrace: assert property (instr_done && instr_is_rte |=> !trace_exc_req) // RQ11
    else $error("Trace raised after exception return");

endmodule

// >>> verif/rtec_seq_model.sv
// Behavioural instruction sequencer facing the exception controller
`timescale 1ns/1ps
module rtec_seq_model (
  // Clock
  input  wire logic hclk,
  // Sequencer outputs
  output logic      instr_done,
  output logic      instr_is_rte,
  output logic      rte_exr_t
);
  initial begin
    instr_done   = 1'b0;
    instr_is_rte = 1'b0;
    rte_exr_t    = 1'b0;
  end
  // Retire one instruction; popped trace bit is only valid with the pulse
  task automatic exec(input logic exception_return_instr, input logic t);
    @(posedge hclk);
    instr_done   <= 1'b1;
    instr_is_rte <= exception_return_instr;
    rte_exr_t    <= t;
    @(posedge hclk);
    instr_done   <= 1'b0;
    instr_is_rte <= 1'b0;
    rte_exr_t    <= ~t;
  endtask
endmodule

// >>> verif/reset_and_trace_exception_ctrl_test.sv
// Self-checking bench of the reset and trace exception controller
`timescale 1ns/1ps
module reset_and_trace_exception_ctrl_test;
  import rtec_pkg::*;
  typedef struct packed {
    logic [1:0] icm;
    logic       t;
    logic       i;
    logic       exception_return_instr;
    logic       trc;
  } rtec_row_s;
  logic        hclk      = 1'b0;
  logic        hresetn   = 1'b0;
  logic        hsel      = 1'b0;
  logic [31:0] haddr     = 32'h0;
  logic [1:0]  htrans    = 2'h0;
  logic        hwrite    = 1'b0;
  logic [31:0] hwdata    = 32'h0;
  logic        nmi_req   = 1'b0;
  logic        irq_req   = 1'b0;
  logic [2:0]  irq_level = 3'h0;
  logic        per_req   = 1'b0;
  logic [3:0]  per_idx   = 4'h0;
  logic        hreadyout, hresp, trace_exc_req, stacked_exr_t, int_accept;
  logic        per_grant, per_blocked, irq, instr_done, instr_is_rte, rte_exr_t;
  logic [31:0] hrdata, rd;
  int          fail_count = 0;
  int          n_tests    = 0;
  rtec_row_s   rows [5]   = '{
    '{ICM_0, 1'b1, 1'b0, 1'b0, 1'b0},
    '{ICM_2, 1'b1, 1'b0, 1'b0, 1'b1},
    '{ICM_2, 1'b0, 1'b0, 1'b0, 1'b0},
    '{ICM_2, 1'b1, 1'b1, 1'b0, 1'b1},
    '{ICM_2, 1'b1, 1'b0, 1'b1, 1'b0}
  };
  always #25 hclk = ~hclk;
  rtec_core u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .instr_done(instr_done),
    .instr_is_rte(instr_is_rte), .rte_exr_t(rte_exr_t), .trace_exc_req(trace_exc_req),
    .stacked_exr_t(stacked_exr_t), .nmi_req(nmi_req), .irq_req(irq_req),
    .irq_level(irq_level), .int_accept(int_accept), .per_req(per_req),
    .per_idx(per_idx), .per_grant(per_grant), .per_blocked(per_blocked), .irq(irq)
  );
  rtec_seq_model u_seq (
    .hclk(hclk), .instr_done(instr_done), .instr_is_rte(instr_is_rte),
    .rte_exr_t(rte_exr_t)
  );
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One single word transfer, address phase then data phase
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk("hresp", hresp, 32'h0);
    @(posedge hclk);
  endtask
  task automatic final_report();
    if (fail_count == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge hclk);
    fail_count++;
    final_report();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (rows[k]) begin
      bus(1'b1, ADDR_CTRL, {30'h0, rows[k].icm});
      bus(1'b1, ADDR_EXR, {24'h0, rows[k].t, 7'h05});
      bus(1'b1, ADDR_CCR, {24'h0, rows[k].i, 7'h40});
      u_seq.exec(rows[k].exception_return_instr, rows[k].t);
      @(negedge hclk);
      chk("trace_exc_req", trace_exc_req, rows[k].trc);
      if (rows[k].trc) chk("stacked_exr_t", stacked_exr_t, 1'b1);
      bus(1'b0, ADDR_EXR, 32'h0);
      chk("exr", rd, {24'h0, rows[k].t & ~rows[k].trc, 7'h05});
      bus(1'b0, ADDR_CCR, 32'h0);
      chk("ccr", rd, {24'h0, rows[k].i | rows[k].trc, 7'h40});
    end
    // Interrupt output: unmasked, masked, cleared
    bus(1'b1, ADDR_MASK, 32'h1);
    @(negedge hclk);
    chk("irq", irq, 1'b1);
    bus(1'b1, ADDR_MASK, 32'h0);
    @(negedge hclk);
    chk("irq", irq, 1'b0);
    bus(1'b1, ADDR_MASK, 32'h1);
    bus(1'b1, ADDR_STAT, 32'h1);
    @(negedge hclk);
    chk("irq", irq, 1'b0);
    bus(1'b0, 8'h1C, 32'h0);
    chk("unmapped", rd, 32'h0);
    // Interrupts inside the trace handler
    u_seq.exec(1'b0, 1'b1);
    @(posedge hclk);
    irq_req   <= 1'b1;
    irq_level <= 3'h6;
    @(negedge hclk);
    chk("int_accept", int_accept, 1'b1);
    @(posedge hclk);
    irq_level <= 3'h4;
    @(negedge hclk);
    chk("int_accept", int_accept, 1'b0);
    // Second reset in mid-run with NMI pending
    @(posedge hclk);
    irq_req <= 1'b0;
    nmi_req <= 1'b1;
    hresetn <= 1'b0;
    repeat (20) @(posedge hclk);
    chk("int_accept", int_accept, 1'b0);
    hresetn <= 1'b1;
    bus(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl", rd, {30'h0, ICM_RESET});
    bus(1'b0, ADDR_EXR, 32'h0);
    chk("exr", rd, {24'h0, EXR_RESET});
    bus(1'b0, ADDR_CCR, 32'h0);
    chk("ccr", rd, {24'h0, CCR_RESET});
    bus(1'b0, ADDR_MSTP, 32'h0);
    chk("mstp", rd, 32'h00003FFF);
    bus(1'b0, ADDR_STATE, 32'h0);
    chk("state", rd, 32'h00000001);
    @(negedge hclk);
    chk("int_accept", int_accept, 1'b0);
    for (int m = 0; m < NUM_MOD; m++) begin
      @(posedge hclk);
      per_req <= 1'b1;
      per_idx <= m[3:0];
      @(negedge hclk);
      chk("per_grant", per_grant, m > 13 ? 1'b1 : 1'b0);
      chk("per_blocked", per_blocked, m > 13 ? 1'b0 : 1'b1);
    end
    bus(1'b0, ADDR_STAT, 32'h0);
    chk("stat", rd, 32'h00000002);
    bus(1'b1, ADDR_MSTP, 32'h0);
    per_idx <= 4'h0;
    @(negedge hclk);
    chk("per_grant", per_grant, 1'b1);
    u_seq.exec(1'b0, 1'b0);
    @(posedge hclk);
    @(negedge hclk);
    chk("int_accept", int_accept, 1'b1);
    final_report();
  end
endmodule
